// ==== core/dacud_top.sv ====
// dac output update, integrity checks, key resets, calibration refresh,
// oscillator monitor and sticky diagnostic flags
// assumes: pins are asynchronous to ref_clk, calibration memory answers
// combinationally to the address, latch readback follows dac_latch at once
//
// Notes on behaviour
// - load strobe low: written code loads at frame select rising edge.
// - load strobe high: code waits for software load or strobe low pulse.
// - watchdog timeout with clear enabled loads the clear code.
// - with slew enabled output register tracks the intermediate code.
// - watchdog fault discards input writes and all load events.
// - after watchdog clear, loads reload clear code until input rewritten.
// - global software load mode ignores the device address bits.
// - code and inverse copy checked before strobing; default enabled.
// - latch monitor compares driven latch code; mismatch sets error flag.
// - software reset only after keys 0x15fa then 0xaf51 back to back.
// - pin, key or watchdog reset sets reset flag; flag is 1 at power-up.
// - each refresh checks crc of shadow data; mismatch sets crc flag.
// - calibration crc check on from reset; config bit disables it.
// - during refresh only readback select and nop writes are allowed.
// - 16-bit counter ticks at oscillator divided by 10,000; default on.
// - stopped oscillator with detection on sends 0x07dead every frame.
// - flags sticky, write 1 reloads with the current fault state.
// - unrefreshed and slew busy flags clear themselves.
// - status holds non-sticky summaries; digital excludes slew busy.
`timescale 1ns/1ps

module dacud_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;
	logic [W-1:0] q_r;

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta_r <= RST;
			q_r <= RST;
		end
		else
		begin
			meta_r <= d;
			q_r <= meta_r;
		end
	end
	assign q = q_r;
endmodule : dacud_sync

module dacud_top #(
	parameter int WDT_CYCLES_P = dacud_pkg::WDT_CYCLES,
	parameter int FREQ_DIV_P = dacud_pkg::FREQ_DIVIDE
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// link pins
	input wire logic frame_sel_n,
	input wire logic load_strobe_n,
	input wire logic [1:0] dev_addr,
	output logic [23:0] sdo_word,
	// converter latches
	output logic [15:0] dac_latch,
	input wire logic [15:0] latch_readback,
	// calibration memory
	output logic [2:0] cal_mem_addr,
	input wire logic [15:0] cal_mem_data,
	input wire logic [7:0] cal_ref_crc,
	// analog monitors
	input wire logic osc_stopped,
	input wire logic [3:0] analog_fault
);
	logic [24:0] sync_q;
	logic sel_s, ld_s, osc_s;
	logic [1:0] addr_s;
	logic [15:0] lrb_s;
	logic [3:0] afault_s;
	logic sel_prev_r, ld_prev_r;
	logic [15:0] pend_r, target_r, out_code_r, out_inv_r, dac_latch_r;
	logic [15:0] clear_code_r, lat_d1_r, lat_d2_r, rdata_r, freq_cnt_r;
	logic [4:0] dac_cfg_r;
	logic gcfg1_r, gcfg2_r, input_seen_r, key1_r, srst_r, wdt_run_r;
	logic [3:0] dcfg_r, rbsel_r, aflags_r;
	logic [2:0] wdt_cfg_r, cal_idx_r, cal_addr_r;
	logic [7:0] dflags_r, crc_r;
	logic [13:0] freq_div_r;
	logic [24:0] wdt_cnt_r;
	logic [11:0] cal_cnt_r;
	logic [23:0] sdo_r;
	dacud_pkg::dacud_cal_t cal_state_r;
	logic cal_busy, wr_ok, invalid_ev, wdt_fault, input_wr, swload_ev;
	logic hw_load_ev, load_ev, wdt_timeout, wdt_kick, key_wr, cal_start;
	logic cal_done, clear_ev, slew_busy, inv_bad, lmon_bad, crc_bad;
	logic [7:0] dset, dclr;
	logic [15:0] gap, slew_nxt, rd_mux;
	logic [2:0] status;

	dacud_sync #(.W(25), .RST(dacud_pkg::SYNC_RST)) u_sync (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.d({frame_sel_n, load_strobe_n, dev_addr, latch_readback,
			osc_stopped, analog_fault}),
		.q(sync_q)
	);
	assign {sel_s, ld_s, addr_s, lrb_s, osc_s, afault_s} = sync_q;

	function automatic logic [7:0] crc_step(input logic [7:0] c,
		input logic [15:0] w);
		logic [7:0] r;
		r = c;
		for (int i = 15; i >= 0; i--)
		begin
			r = (r[7] ^ w[i]) ? ({r[6:0], 1'b0} ^ dacud_pkg::CRC_POLY)
				: {r[6:0], 1'b0};
		end
		return r;
	endfunction : crc_step

	// decode and events
	assign cal_busy = cal_state_r != dacud_pkg::CAL_IDLE;
	assign wr_ok = reg_wr && (!cal_busy || reg_addr == dacud_pkg::OFS_RBSEL
		|| reg_addr == dacud_pkg::OFS_NOP);
	assign invalid_ev = reg_wr && !wr_ok;
	assign wdt_fault = dflags_r[dacud_pkg::FL_WDT];
	assign input_wr = wr_ok && reg_addr == dacud_pkg::OFS_INPUT
		&& !wdt_fault;
	assign swload_ev = wr_ok && reg_addr == dacud_pkg::OFS_SW_LOAD
		&& reg_wdata[dacud_pkg::SWL_CMD] && !wdt_fault
		&& (gcfg2_r || reg_wdata[2:1] == addr_s);
	assign hw_load_ev = !wdt_fault && ((sel_s && !sel_prev_r && !ld_s
		&& input_seen_r) || (!ld_s && ld_prev_r));
	assign load_ev = swload_ev || hw_load_ev;
	assign wdt_timeout = wdt_run_r && wdt_cnt_r == 25'(WDT_CYCLES_P - 1);
	assign clear_ev = wdt_timeout && wdt_cfg_r[dacud_pkg::WC_CLEAR];
	assign key_wr = wr_ok && reg_addr == dacud_pkg::OFS_KEY;
	assign wdt_kick = key_wr && reg_wdata == dacud_pkg::KEY_WDT;
	assign cal_start = !cal_busy && ((key_wr
		&& reg_wdata == dacud_pkg::KEY_CAL) || (wr_ok
		&& reg_addr == dacud_pkg::OFS_DAC_CFG
		&& reg_wdata[3:0] != dac_cfg_r[3:0]));
	assign cal_done = cal_state_r == dacud_pkg::CAL_WAIT
		&& cal_cnt_r == 12'(dacud_pkg::CAL_CYCLES - 1);
	assign crc_bad = cal_done && dcfg_r[dacud_pkg::DC_CRC_EN]
		&& crc_r != cal_ref_crc;
	assign slew_busy = out_code_r != target_r;
	assign inv_bad = dcfg_r[dacud_pkg::DC_INV_EN]
		&& out_code_r != ~out_inv_r;
	assign lmon_bad = dcfg_r[dacud_pkg::DC_LMON_EN]
		&& lrb_s != lat_d2_r;
	assign gap = (target_r > out_code_r) ? target_r - out_code_r
		: out_code_r - target_r;

	always_comb
	begin
		if (!dac_cfg_r[dacud_pkg::CFG_SLEW_EN] || gap <= dacud_pkg::SLEW_STEP)
			slew_nxt = target_r;
		else if (target_r > out_code_r)
			slew_nxt = out_code_r + dacud_pkg::SLEW_STEP;
		else
			slew_nxt = out_code_r - dacud_pkg::SLEW_STEP;
	end

	// pin edge history
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sel_prev_r <= 1'b1;
			ld_prev_r <= 1'b1;
		end
		else
		begin
			sel_prev_r <= sel_s;
			ld_prev_r <= ld_s;
		end
	end

	// input code, pending code and load
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pend_r <= 16'h0000;
			target_r <= 16'h0000;
			input_seen_r <= 1'b0;
		end
		else if (srst_r)
		begin
			pend_r <= 16'h0000;
			target_r <= 16'h0000;
			input_seen_r <= 1'b0;
		end
		else if (clear_ev)
		begin
			pend_r <= clear_code_r;
			target_r <= clear_code_r;
			input_seen_r <= 1'b0;
		end
		else
		begin
			if (input_wr)
				pend_r <= reg_wdata;
			if (load_ev)
				target_r <= pend_r;
			if (input_wr)
				input_seen_r <= 1'b1;
			else if (load_ev)
				input_seen_r <= 1'b0;
		end
	end

	// output code with inverse copy and latch strobe
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			out_code_r <= 16'h0000;
			out_inv_r <= 16'hffff;
			dac_latch_r <= 16'h0000;
			lat_d1_r <= 16'h0000;
			lat_d2_r <= 16'h0000;
		end
		else
		begin
			out_code_r <= slew_nxt;
			out_inv_r <= ~slew_nxt;
			if (!inv_bad)
				dac_latch_r <= out_code_r;
			lat_d1_r <= dac_latch_r;
			lat_d2_r <= lat_d1_r;
		end
	end

	// configuration registers
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			clear_code_r <= 16'h0000;
			dac_cfg_r <= 5'h00;
			gcfg1_r <= dacud_pkg::GCFG1_RST;
			gcfg2_r <= 1'b0;
			dcfg_r <= dacud_pkg::DCFG_RST;
			wdt_cfg_r <= 3'h0;
			rbsel_r <= 4'h0;
		end
		else if (srst_r)
		begin
			clear_code_r <= 16'h0000;
			dac_cfg_r <= 5'h00;
			gcfg1_r <= dacud_pkg::GCFG1_RST;
			gcfg2_r <= 1'b0;
			dcfg_r <= dacud_pkg::DCFG_RST;
			wdt_cfg_r <= 3'h0;
			rbsel_r <= 4'h0;
		end
		else if (wr_ok)
		begin
			case (reg_addr)
				dacud_pkg::OFS_CLEAR: clear_code_r <= reg_wdata;
				dacud_pkg::OFS_DAC_CFG: dac_cfg_r <= reg_wdata[4:0];
				dacud_pkg::OFS_GCFG1: gcfg1_r <= reg_wdata[0];
				dacud_pkg::OFS_GCFG2: gcfg2_r <= reg_wdata[0];
				dacud_pkg::OFS_DCFG: dcfg_r <= reg_wdata[3:0];
				dacud_pkg::OFS_WDT_CFG: wdt_cfg_r <= reg_wdata[2:0];
				dacud_pkg::OFS_RBSEL: rbsel_r <= reg_wdata[3:0];
				default: ;
			endcase
		end
	end

	// key sequence and software reset
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			key1_r <= 1'b0;
			srst_r <= 1'b0;
		end
		else
		begin
			key1_r <= key_wr && reg_wdata == dacud_pkg::KEY_RESET1
				? 1'b1 : (reg_wr ? 1'b0 : key1_r);
			srst_r <= (key1_r && key_wr
				&& reg_wdata == dacud_pkg::KEY_RESET2)
				|| (wdt_timeout && wdt_cfg_r[dacud_pkg::WC_RESET]);
		end
	end

	// watchdog timer
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wdt_run_r <= 1'b0;
			wdt_cnt_r <= 25'h0;
		end
		else if (srst_r || wdt_timeout || !wdt_cfg_r[dacud_pkg::WC_EN])
		begin
			wdt_run_r <= 1'b0;
			wdt_cnt_r <= 25'h0;
		end
		else if (wdt_kick && !wdt_fault)
		begin
			wdt_run_r <= 1'b1;
			wdt_cnt_r <= 25'h0;
		end
		else if (wdt_run_r)
			wdt_cnt_r <= wdt_cnt_r + 25'h1;
	end

	// calibration refresh sequencer
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cal_state_r <= dacud_pkg::CAL_IDLE;
			cal_idx_r <= 3'h0;
			cal_addr_r <= 3'h0;
			cal_cnt_r <= 12'h000;
			crc_r <= dacud_pkg::CRC_INIT;
		end
		else
		begin
			case (cal_state_r)
				dacud_pkg::CAL_IDLE:
				begin
					if (cal_start)
					begin
						cal_state_r <= dacud_pkg::CAL_READ;
						cal_idx_r <= 3'h0;
						cal_addr_r <= 3'h0;
						crc_r <= dacud_pkg::CRC_INIT;
					end
				end
				dacud_pkg::CAL_READ:
				begin
					crc_r <= crc_step(crc_r, cal_mem_data);
					cal_idx_r <= cal_idx_r + 3'h1;
					cal_addr_r <= cal_idx_r + 3'h1;
					cal_cnt_r <= 12'h000;
					if (cal_idx_r == dacud_pkg::CAL_WORDS_LAST)
						cal_state_r <= dacud_pkg::CAL_WAIT;
				end
				dacud_pkg::CAL_WAIT:
				begin
					cal_addr_r <= 3'h0;
					cal_cnt_r <= cal_cnt_r + 12'h001;
					if (cal_done)
						cal_state_r <= dacud_pkg::CAL_IDLE;
				end
				default: cal_state_r <= dacud_pkg::CAL_IDLE;
			endcase
		end
	end

	// frequency monitor
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			freq_div_r <= 14'h0000;
			freq_cnt_r <= 16'h0000;
		end
		else if (srst_r || !dcfg_r[dacud_pkg::DC_FREQ_EN])
			freq_div_r <= 14'h0000;
		else if (freq_div_r == 14'(FREQ_DIV_P - 1))
		begin
			freq_div_r <= 14'h0000;
			freq_cnt_r <= freq_cnt_r + 16'h0001;
		end
		else
			freq_div_r <= freq_div_r + 14'h0001;
	end

	// diagnostic flags: set wins over the write-1 clear
	always_comb
	begin
		dset = 8'h00;
		dset[dacud_pkg::FL_RESET] = srst_r;
		dset[dacud_pkg::FL_CRC] = crc_bad;
		dset[dacud_pkg::FL_INVALID] = invalid_ev;
		dset[dacud_pkg::FL_LMON] = lmon_bad;
		dset[dacud_pkg::FL_INV] = inv_bad;
		dset[dacud_pkg::FL_WDT] = wdt_timeout;
		dclr = (wr_ok && reg_addr == dacud_pkg::OFS_DFLAGS)
			? reg_wdata[7:0] : 8'h00;
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			dflags_r <= dacud_pkg::DFLAGS_RST;
			aflags_r <= 4'h0;
		end
		else
		begin
			dflags_r[5:0] <= (dflags_r[5:0] & ~dclr[5:0])
				| dset[5:0];
			if (srst_r)
				dflags_r[dacud_pkg::FL_UNREF] <= 1'b1;
			else if (cal_done)
				dflags_r[dacud_pkg::FL_UNREF] <= 1'b0;
			dflags_r[dacud_pkg::FL_SLEW] <= slew_busy;
			aflags_r <= (aflags_r & ~((wr_ok
				&& reg_addr == dacud_pkg::OFS_AFLAGS)
				? reg_wdata[3:0] : 4'h0)) | afault_s;
		end
	end

	assign status = {wdt_fault, |aflags_r,
		|dflags_r[6:0]};

	// read port and serial output word
	always_comb
	begin
		case (reg_addr)
			dacud_pkg::OFS_INPUT: rd_mux = pend_r;
			dacud_pkg::OFS_OUTPUT: rd_mux = out_code_r;
			dacud_pkg::OFS_CLEAR: rd_mux = clear_code_r;
			dacud_pkg::OFS_DAC_CFG: rd_mux = {11'h000, dac_cfg_r};
			dacud_pkg::OFS_GCFG1: rd_mux = {15'h0000, gcfg1_r};
			dacud_pkg::OFS_GCFG2: rd_mux = {15'h0000, gcfg2_r};
			dacud_pkg::OFS_DCFG: rd_mux = {12'h000, dcfg_r};
			dacud_pkg::OFS_DFLAGS: rd_mux = {8'h00, dflags_r};
			dacud_pkg::OFS_AFLAGS: rd_mux = {12'h000, aflags_r};
			dacud_pkg::OFS_STATUS: rd_mux = {13'h0000, status};
			dacud_pkg::OFS_FREQ: rd_mux = freq_cnt_r;
			dacud_pkg::OFS_RBSEL: rd_mux = {12'h000, rbsel_r};
			dacud_pkg::OFS_WDT_CFG: rd_mux = {13'h0000, wdt_cfg_r};
			default: rd_mux = 16'h0000;
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rdata_r <= 16'h0000;
			sdo_r <= 24'h000000;
		end
		else
		begin
			rdata_r <= reg_rd ? rd_mux : 16'h0000;
			if (!sel_s && sel_prev_r)
				sdo_r <= (osc_s && gcfg1_r) ? dacud_pkg::OSC_DEAD_CODE
					: {21'h000000, status};
		end
	end

	assign reg_rdata = rdata_r;
	assign sdo_word = sdo_r;
	assign dac_latch = dac_latch_r;
	assign cal_mem_addr = cal_addr_r;
endmodule : dacud_top

// ==== core/dacud_pkg.sv ====
// constants and types for the dac update and integrity block
// assumes a 25 MHz reference clock, used both as bus clock and oscillator
package dacud_pkg;
	// timing
	localparam int CLK_HZ = 25_000_000;
	localparam int WDT_TIMEOUT_MS = 1000;
	localparam int WDT_CYCLES = (CLK_HZ / 1000) * WDT_TIMEOUT_MS;
	localparam int CAL_REFRESH_US = 100;
	localparam int CAL_CYCLES = (CLK_HZ / 1_000_000) * CAL_REFRESH_US;
	localparam int FREQ_DIVIDE = 10000;
	localparam logic [2:0] CAL_WORDS_LAST = 3'h7;
	localparam logic [15:0] SLEW_STEP = 16'h0100;
	// register indexes
	localparam logic [3:0] OFS_INPUT = 4'h0;
	localparam logic [3:0] OFS_OUTPUT = 4'h1;
	localparam logic [3:0] OFS_CLEAR = 4'h2;
	localparam logic [3:0] OFS_DAC_CFG = 4'h3;
	localparam logic [3:0] OFS_SW_LOAD = 4'h4;
	localparam logic [3:0] OFS_KEY = 4'h5;
	localparam logic [3:0] OFS_GCFG1 = 4'h6;
	localparam logic [3:0] OFS_GCFG2 = 4'h7;
	localparam logic [3:0] OFS_DCFG = 4'h8;
	localparam logic [3:0] OFS_DFLAGS = 4'h9;
	localparam logic [3:0] OFS_AFLAGS = 4'ha;
	localparam logic [3:0] OFS_STATUS = 4'hb;
	localparam logic [3:0] OFS_FREQ = 4'hc;
	localparam logic [3:0] OFS_RBSEL = 4'hd;
	localparam logic [3:0] OFS_NOP = 4'he;
	localparam logic [3:0] OFS_WDT_CFG = 4'hf;
	// key codes
	localparam logic [15:0] KEY_RESET1 = 16'h15fa;
	localparam logic [15:0] KEY_RESET2 = 16'haf51;
	localparam logic [15:0] KEY_CAL = 16'hfcba;
	localparam logic [15:0] KEY_WDT = 16'h0d06;
	// field positions
	localparam int SWL_CMD = 0;
	localparam int GC1_OSC_EN = 0;
	localparam int GC2_GLOBAL = 0;
	localparam int DC_INV_EN = 0;
	localparam int DC_LMON_EN = 1;
	localparam int DC_CRC_EN = 2;
	localparam int DC_FREQ_EN = 3;
	localparam int CFG_SLEW_EN = 4;
	localparam int WC_EN = 0;
	localparam int WC_CLEAR = 1;
	localparam int WC_RESET = 2;
	localparam int FL_RESET = 0;
	localparam int FL_CRC = 1;
	localparam int FL_INVALID = 2;
	localparam int FL_LMON = 3;
	localparam int FL_INV = 4;
	localparam int FL_WDT = 5;
	localparam int FL_UNREF = 6;
	localparam int FL_SLEW = 7;
	// reset values
	localparam logic [7:0] DFLAGS_RST = 8'h41;
	localparam logic [3:0] DCFG_RST = 4'hd;
	localparam logic GCFG1_RST = 1'b1;
	localparam logic [24:0] SYNC_RST = 25'h1_800000;
	localparam logic [7:0] CRC_INIT = 8'hff;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [23:0] OSC_DEAD_CODE = 24'h07dead;
	// calibration refresh sequencer
	typedef enum logic [2:0] {
		CAL_IDLE = 3'b001,
		CAL_READ = 3'b010,
		CAL_WAIT = 3'b100
	} dacud_cal_t;
endpackage : dacud_pkg

// ==== dv/dacud_top_chk.sv ====
// port checker for dacud_top
// assumes a bind onto dacud_top, one clock domain
`timescale 1ns/1ps
module dacud_top_chk #(
	parameter int WDT_CYCLES_P = 50,
	parameter int FREQ_DIV_P = 10
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// register port
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	// link and monitors
	input wire logic frame_sel_n,
	input wire logic [23:0] sdo_word,
	input wire logic osc_stopped,
	input wire logic [3:0] analog_fault,
	// calibration memory
	input wire logic [2:0] cal_mem_addr
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);
	logic [5:0] frm_r;
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			frm_r <= 6'h3f;
		else
			frm_r <= {frm_r[4:0], frame_sel_n};
	end
	property p_rd_idle;
		!$past(reg_rd) |-> reg_rdata == 16'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside read cycle");
	property p_sdo_frame;
		$changed(sdo_word) |-> (frm_r[5:1] & ~frm_r[4:0]) != 5'h0;
	endproperty
	a_sdo_frame: assert property (p_sdo_frame)
		else $error("serial word changed without frame");
	property p_sdo_dead;
		$fell(frame_sel_n) && osc_stopped && $past(osc_stopped, 4)
			|-> ##5 sdo_word == dacud_pkg::OSC_DEAD_CODE;
	endproperty
	a_sdo_dead: assert property (p_sdo_dead)
		else $error("dead code missing");
	property p_sdo_live;
		$fell(frame_sel_n) && !osc_stopped && !$past(osc_stopped, 4)
			|-> ##5 sdo_word[23:3] == 21'h0;
	endproperty
	a_sdo_live: assert property (p_sdo_live)
		else $error("status word upper bits set");
	property p_sdo_ana;
		$fell(frame_sel_n) && !osc_stopped && !$past(osc_stopped, 4)
			&& $past(analog_fault, 4) != 4'h0 |-> ##5 sdo_word[1];
	endproperty
	a_sdo_ana: assert property (p_sdo_ana)
		else $error("analog summary missing");
	property p_sdo_form;
		sdo_word[23:3] == 21'h0 || sdo_word == dacud_pkg::OSC_DEAD_CODE;
	endproperty
	a_sdo_form: assert property (p_sdo_form)
		else $error("serial word malformed");
	property p_cal_step;
		cal_mem_addr inside {[3'h1:3'h6]}
			|=> cal_mem_addr == $past(cal_mem_addr) + 3'h1;
	endproperty
	a_cal_step: assert property (p_cal_step)
		else $error("calibration walk skipped");
	property p_cal_first;
		$past(cal_mem_addr) == 3'h0 && cal_mem_addr != 3'h0
			|-> cal_mem_addr == 3'h1;
	endproperty
	a_cal_first: assert property (p_cal_first)
		else $error("calibration walk bad start");
	c_dead: cover property (sdo_word == dacud_pkg::OSC_DEAD_CODE);
	c_cal: cover property (cal_mem_addr == 3'h7);
	c_ana: cover property (sdo_word[1]);
endmodule : dacud_top_chk

bind dacud_top dacud_top_chk #(
	.WDT_CYCLES_P(WDT_CYCLES_P),
	.FREQ_DIV_P(FREQ_DIV_P)
) i_chk (
	.ref_clk(ref_clk),
	.arst_n(arst_n),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.frame_sel_n(frame_sel_n),
	.sdo_word(sdo_word),
	.osc_stopped(osc_stopped),
	.analog_fault(analog_fault),
	.cal_mem_addr(cal_mem_addr)
);

// ==== dv/dacud_far_model.sv ====
// far side: calibration memory and converter latches
// assumes latches follow their code in the same cycle
`timescale 1ns/1ps
module dacud_far_model (
	// calibration memory
	input wire logic [2:0] cal_mem_addr,
	output logic [15:0] cal_mem_data,
	// converter latches
	input wire logic [15:0] dac_latch,
	input wire logic corrupt,
	output logic [15:0] latch_readback
);
	assign cal_mem_data = {cal_mem_addr, 5'h0a, ~cal_mem_addr, 5'h15};
	// upset on bit 0 on demand
	assign latch_readback = dac_latch ^ {15'h0, corrupt};
endmodule : dacud_far_model

// ==== dv/tb_dacud_top.sv ====
// bench for dacud_top with a far-side model
// assumes the checker is bound in by its own file
`timescale 1ns/1ps
module tb_dacud_top;
	localparam int DIV_P = 10;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic frame_sel_n = 1'b1;
	logic load_strobe_n = 1'b1;
	logic [1:0] dev_addr = 2'h2;
	logic [23:0] sdo_word;
	logic [15:0] dac_latch;
	logic [15:0] latch_readback;
	logic [2:0] cal_mem_addr;
	logic [15:0] cal_mem_data;
	logic [7:0] cal_ref_crc = 8'h0;
	logic osc_stopped = 1'b0;
	logic [3:0] analog_fault = 4'h0;
	logic corrupt = 1'b0;
	logic [15:0] rv;
	int bad_count = 0;
	int cmp_count = 0;
	int m_out = 0;
	int m_code;
	int base;
	initial
	begin
		forever #20 ref_clk = ~ref_clk;
	end
	dacud_top #(.WDT_CYCLES_P(50), .FREQ_DIV_P(DIV_P)) i_dut (
		.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .frame_sel_n(frame_sel_n),
		.load_strobe_n(load_strobe_n), .dev_addr(dev_addr),
		.sdo_word(sdo_word), .dac_latch(dac_latch),
		.latch_readback(latch_readback), .cal_mem_addr(cal_mem_addr),
		.cal_mem_data(cal_mem_data), .cal_ref_crc(cal_ref_crc),
		.osc_stopped(osc_stopped), .analog_fault(analog_fault)
	);
	dacud_far_model i_far (
		.cal_mem_addr(cal_mem_addr), .cal_mem_data(cal_mem_data),
		.dac_latch(dac_latch), .corrupt(corrupt),
		.latch_readback(latch_readback)
	);
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : tick
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		rv = reg_rdata;
	endtask : rd
	task automatic chk(input string n, input logic [23:0] e, logic [23:0] g);
		cmp_count++;
		if (g !== e)
		begin
			$display("[FAIL] %s expected %h seen %h", n, e, g);
			bad_count++;
		end
	endtask : chk
	task automatic rchk(string n, logic [3:0] a, logic [15:0] m, e);
		rd(a);
		chk(n, {8'h0, e}, {8'h0, rv & m});
	endtask : rchk
	task automatic ochk(input string n);
		tick(4);
		rchk(n, 4'h1, 16'hffff, m_out[15:0]);
		chk(n, {8'h0, m_out[15:0]}, {8'h0, dac_latch});
	endtask : ochk
	task automatic frame;
		@(posedge ref_clk);
		frame_sel_n <= 1'b0;
		tick(4);
		frame_sel_n <= 1'b1;
		tick(4);
	endtask : frame
	task automatic pin(input logic v);
		@(posedge ref_clk);
		load_strobe_n <= v;
	endtask : pin
	function automatic logic [7:0] crc_of(input logic [7:0] flip);
		logic [7:0] c;
		logic [15:0] w;
		c = 8'hff;
		for (int i = 0; i < 8; i++)
		begin
			w = {3'(i), 5'h0a, ~3'(i), 5'h15};
			for (int b = 15; b >= 0; b--)
				c = {c[6:0], 1'b0} ^ ((c[7] ^ w[b]) ? 8'h07 : 8'h00);
		end
		return c ^ flip;
	endfunction : crc_of
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize
	initial
	begin
		#1_000_000;
		bad_count++;
		summarize();
	end
	initial
	begin
		void'($urandom(90));
		tick(5);
		arst_n <= 1'b1;
		tick(2);
		rchk("flags", 4'h9, 16'h00ff, 16'h0041);
		rchk("diag cfg", 4'h8, 16'h000f, 16'h000d);
		rchk("osc cfg", 4'h6, 16'h0001, 16'h0001);
		pin(1'b0);
		// let the synced strobe edge pass before the code is written
		tick(3);
		m_code = $urandom;
		wr(4'h0, m_code[15:0]);
		ochk("before frame");
		frame;
		m_out = m_code;
		ochk("frame load");
		pin(1'b1);
		m_code = $urandom;
		wr(4'h0, m_code[15:0]);
		frame;
		wr(4'h4, {13'h0, ~dev_addr, 1'b1});
		ochk("held");
		wr(4'h4, {13'h0, dev_addr, 1'b1});
		m_out = m_code;
		ochk("sw load");
		m_code = $urandom;
		wr(4'h0, m_code[15:0]);
		pin(1'b0);
		tick(3);
		load_strobe_n <= 1'b1;
		m_out = m_code;
		ochk("pin load");
		wr(4'h7, 16'h0001);
		m_code = $urandom;
		wr(4'h0, m_code[15:0]);
		wr(4'h4, {13'h0, ~dev_addr, 1'b1});
		m_out = m_code;
		ochk("global load");
		wr(4'h7, 16'h0000);
		m_code = $urandom;
		wr(4'h2, m_code[15:0]);
		wr(4'hf, 16'h0003);
		wr(4'h5, dacud_pkg::KEY_WDT);
		tick(70);
		m_out = m_code;
		ochk("clear code");
		rchk("wdt flag", 4'h9, 16'h0020, 16'h0020);
		wr(4'h0, 16'h1234);
		wr(4'h4, {13'h0, dev_addr, 1'b1});
		ochk("fault gate");
		wr(4'hf, 16'h0000);
		wr(4'h9, 16'h0020);
		wr(4'h4, {13'h0, dev_addr, 1'b1});
		ochk("reload clear");
		rd(4'h3);
		wr(4'h3, rv | 16'h0010);
		m_code = m_out ^ 32'h8000;
		wr(4'h0, m_code[15:0]);
		wr(4'h4, {13'h0, dev_addr, 1'b1});
		tick(3);
		rchk("slew busy", 4'h9, 16'h0080, 16'h0080);
		rd(4'h1);
		chk("mid", 24'h1, {23'h0, rv !== m_code[15:0] && rv !== m_out[15:0]});
		tick(300);
		m_out = m_code;
		ochk("slew end");
		rchk("slew done", 4'h9, 16'h0080, 16'h0000);
		wr(4'h8, 16'h000f);
		tick(5);
		rchk("latch ok", 4'h9, 16'h0018, 16'h0000);
		@(posedge ref_clk);
		corrupt <= 1'b1;
		tick(6);
		wr(4'h9, 16'h0008);
		rchk("latch err", 4'h9, 16'h0008, 16'h0008);
		@(posedge ref_clk);
		corrupt <= 1'b0;
		tick(6);
		wr(4'h9, 16'h0008);
		rchk("latch clr", 4'h9, 16'h0008, 16'h0000);
		rd(4'hc);
		base = rv;
		tick(98);
		rd(4'hc);
		chk("freq", {8'h0, 16'(base + 100 / DIV_P)}, {8'h0, rv});
		wr(4'h9, 16'h0001);
		wr(4'h5, dacud_pkg::KEY_RESET1);
		wr(4'h5, 16'h1234);
		tick(4);
		rchk("bad key", 4'h9, 16'h0001, 16'h0000);
		wr(4'h5, dacud_pkg::KEY_RESET1);
		wr(4'h5, dacud_pkg::KEY_RESET2);
		tick(4);
		rchk("sw reset", 4'h9, 16'h0041, 16'h0041);
		rchk("cfg back", 4'h8, 16'h000f, 16'h000d);
		@(posedge ref_clk);
		cal_ref_crc <= crc_of(8'h00);
		wr(4'h5, dacud_pkg::KEY_CAL);
		wr(4'he, 16'h0000);
		rchk("nop ok", 4'h9, 16'h0004, 16'h0000);
		wr(4'h2, 16'h0000);
		tick(dacud_pkg::CAL_CYCLES + 30);
		rchk("cal good", 4'h9, 16'h0046, 16'h0004);
		wr(4'h9, 16'h0004);
		@(posedge ref_clk);
		cal_ref_crc <= crc_of(8'h01);
		rd(4'h3);
		wr(4'h3, rv ^ 16'h0001);
		tick(dacud_pkg::CAL_CYCLES + 30);
		rchk("cal bad", 4'h9, 16'h0006, 16'h0002);
		@(posedge ref_clk);
		analog_fault <= 4'h9;
		tick(6);
		frame;
		chk("sdo status", 24'h000003, sdo_word);
		rchk("status", 4'hb, 16'h0007, 16'h0003);
		@(posedge ref_clk);
		analog_fault <= 4'h0;
		tick(4);
		wr(4'ha, 16'h000f);
		rchk("ana clr", 4'ha, 16'h000f, 16'h0000);
		@(posedge ref_clk);
		osc_stopped <= 1'b1;
		tick(6);
		frame;
		chk("dead code", dacud_pkg::OSC_DEAD_CODE, sdo_word);
		summarize();
	end
endmodule : tb_dacud_top
